// [src/gen_ctrl_pkg.sv]
// Constants for the general control register block.
// What this block does
// - Select clear: pair five is plain PCI.
// - Select set: pair five runs sideband DMA.
// - GPIO use-select set: pair five becomes GPIO.
// - Hide set: AD22 low on bridge config cycles.
// - Break enable clear: ignore FPU error.
// - Break enable set: FPU error ends low-power.
// - Coprocessor enable clear: no IRQ, no ignore.
// - Enable set, error low: IRQ until an F0h write made with the error line high.
// - Enable set, error low: drive ignore-numeric active.
// - Keyboard latch clear: line passes straight through.
// - Keyboard latch set: edge held until 60h read.
// - Mouse latch set: edge held until 60h read.
package gen_ctrl_pkg;
    localparam logic [7:0] GENERAL_CONTROL_OFFSET = 8'hd0;
    localparam logic [31:0] GENERAL_CONTROL_RESET = 32'h0000_0000;
    localparam logic [31:0] GENERAL_CONTROL_WMASK = 32'h0320_3800;
    localparam int REQ5_SIDEBAND_PROTOCOL_SELECT_BIT = 25;
    localparam int HIDE_LEGACY_BRIDGE_BIT = 24;
    localparam int FPU_ERROR_BREAK_EVENT_EN_BIT = 21;
    localparam int COPROC_ERROR_IRQ_EN_BIT = 13;
    localparam int KBD_IRQ_LATCH_EN_BIT = 12;
    localparam int MOUSE_IRQ_LATCH_EN_BIT = 11;
    localparam int PIN_SYNC_WIDTH = 4;
endpackage

// [src/irq_edge_latch.sv]
// Edge latch for one legacy interrupt line with bypass.
`timescale 1ns/1ps
module irq_edge_latch (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Control
    input wire logic latch_en,
    input wire logic clear_pulse,
    // Interrupt line
    input wire logic irq_in,
    output logic irq_out
);
    logic prev_reg;
    logic held_reg;
    logic rise;

    assign rise = irq_in & ~prev_reg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= irq_in;
        end
    end

    // A new edge in the clearing cycle wins, so no keystroke is lost.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            held_reg <= 1'b0;
        end else if (!latch_en) begin
            held_reg <= 1'b0;
        end else if (rise) begin
            held_reg <= 1'b1;
        end else if (clear_pulse) begin
            held_reg <= 1'b0;
        end
    end

    assign irq_out = latch_en ? held_reg : irq_in;
endmodule

// [src/lpc_general_control.sv]
// General control register and the side logic its bits steer.
`timescale 1ns/1ps
module lpc_general_control
    import gen_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Configuration space access
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    // Legacy I/O port decodes, one-cycle pulses
    input wire logic io_wr_f0,
    input wire logic io_rd_60,
    // Request/grant pair five
    input wire logic req5_n_pin,
    output logic gnt5_n_pin,
    input wire logic gpio_use_sel_req5,
    output logic arb_req5_n,
    input wire logic arb_gnt5_n,
    output logic sideband_req_b_n,
    input wire logic sideband_gnt_b_n,
    output logic gpi_req5,
    input wire logic gpo_gnt5,
    // Address line 22
    input wire logic ad22_core,
    input wire logic cfg_to_legacy_bridge,
    output logic ad22_pin_out,
    // Processor error and low-power
    input wire logic fpu_error_n,
    input wire logic in_low_power,
    output logic break_event,
    output logic fpu_error_interrupt,
    output logic ignore_numeric_error_n,
    // Keyboard and mouse interrupts
    input wire logic keyboard_interrupt,
    input wire logic mouse_interrupt,
    output logic kbd_irq_out,
    output logic mouse_irq_out
);
    logic [31:0] general_control_reg;
    logic [31:0] general_control_next;
    logic [PIN_SYNC_WIDTH-1:0] sync1_reg;
    logic [PIN_SYNC_WIDTH-1:0] sync2_reg;
    logic req5_s;
    logic fpu_err_s;
    logic kbd_s;
    logic mouse_s;
    logic sel_side;
    logic hide;
    logic brk_en;
    logic copr_en;
    logic kbd_en;
    logic mouse_en;
    logic reg_hit;
    logic fpu_err_active;

    // Pins pass two flops; only the second stage is read.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_reg <= 4'h3;
            sync2_reg <= 4'h3;
        end else begin
            sync1_reg <= {mouse_interrupt, keyboard_interrupt, fpu_error_n, req5_n_pin};
            sync2_reg <= sync1_reg;
        end
    end

    assign req5_s = sync2_reg[0];
    assign fpu_err_s = sync2_reg[1];
    assign kbd_s = sync2_reg[2];
    assign mouse_s = sync2_reg[3];

    assign sel_side = general_control_reg[REQ5_SIDEBAND_PROTOCOL_SELECT_BIT];
    assign hide = general_control_reg[HIDE_LEGACY_BRIDGE_BIT];
    assign brk_en = general_control_reg[FPU_ERROR_BREAK_EVENT_EN_BIT];
    assign copr_en = general_control_reg[COPROC_ERROR_IRQ_EN_BIT];
    assign kbd_en = general_control_reg[KBD_IRQ_LATCH_EN_BIT];
    assign mouse_en = general_control_reg[MOUSE_IRQ_LATCH_EN_BIT];
    assign reg_hit = cfg_addr == GENERAL_CONTROL_OFFSET;

    // Byte-enabled write; reserved positions are masked off.
    always_comb begin
        general_control_next = general_control_reg;
        for (int i = 0; i < 4; i++) begin
            if (cfg_be[i]) begin
                general_control_next[i*8 +: 8] = cfg_wdata[i*8 +: 8];
            end
        end
        general_control_next = general_control_next & GENERAL_CONTROL_WMASK;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            general_control_reg <= GENERAL_CONTROL_RESET;
        end else if (cfg_wr && reg_hit) begin
            general_control_reg <= general_control_next;
        end
    end

    // Reads of other offsets return zero so foreign decode stays harmless.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_rdata <= 32'h0000_0000;
        end else if (cfg_rd) begin
            cfg_rdata <= reg_hit ? general_control_reg : 32'h0000_0000;
        end
    end

    // GPIO use-select overrides the protocol select, so it is checked first.
    always_comb begin
        arb_req5_n = 1'b1;
        sideband_req_b_n = 1'b1;
        gpi_req5 = req5_s;
        if (gpio_use_sel_req5) begin
            gnt5_n_pin = gpo_gnt5;
        end else if (sel_side) begin
            sideband_req_b_n = req5_s;
            gnt5_n_pin = sideband_gnt_b_n;
        end else begin
            arb_req5_n = req5_s;
            gnt5_n_pin = arb_gnt5_n;
        end
    end

    // The bridge sees its select only through this line.
    assign ad22_pin_out = ad22_core & ~(hide & cfg_to_legacy_bridge);

    assign fpu_err_active = ~fpu_err_s;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            break_event <= 1'b0;
        end else begin
            break_event <= brk_en & in_low_power & fpu_err_active;
        end
    end

    // The F0h write clears only once the error line is high; while it is low the set wins.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fpu_error_interrupt <= 1'b0;
        end else if (!copr_en) begin
            fpu_error_interrupt <= 1'b0;
        end else if (fpu_err_active) begin
            fpu_error_interrupt <= 1'b1;
        end else if (io_wr_f0) begin
            fpu_error_interrupt <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ignore_numeric_error_n <= 1'b1;
        end else begin
            ignore_numeric_error_n <= ~(copr_en & fpu_err_active);
        end
    end

    irq_edge_latch kbd_latch (
        .clk(clk),
        .rst_b(rst_b),
        .latch_en(kbd_en),
        .clear_pulse(io_rd_60),
        .irq_in(kbd_s),
        .irq_out(kbd_irq_out)
    );

    irq_edge_latch mouse_latch (
        .clk(clk),
        .rst_b(rst_b),
        .latch_en(mouse_en),
        .clear_pulse(io_rd_60),
        .irq_in(mouse_s),
        .irq_out(mouse_irq_out)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    req5_std_a: assert property (
        !gpio_use_sel_req5 && !sel_side |-> arb_req5_n == req5_s
            && gnt5_n_pin == arb_gnt5_n && sideband_req_b_n)
        else $error("Pair five not routed to arbiter.");

    req5_side_a: assert property (
        !gpio_use_sel_req5 && sel_side |-> sideband_req_b_n == req5_s
            && gnt5_n_pin == sideband_gnt_b_n && arb_req5_n)
        else $error("Pair five not routed to sideband.");

    req5_gpio_a: assert property (
        gpio_use_sel_req5 |-> gnt5_n_pin == gpo_gnt5 && arb_req5_n && sideband_req_b_n)
        else $error("Pair five not used as GPIO.");

    ad22_hide_a: assert property (
        hide && cfg_to_legacy_bridge |-> !ad22_pin_out)
        else $error("AD22 driven on hidden bridge cycle.");

    fpu_ignore_a: assert property (
        !brk_en |=> !break_event)
        else $error("Break event while disabled.");

    // The pin takes two sync stages and the break register one more edge.
    fpu_break_a: assert property (
        brk_en && in_low_power && !fpu_error_n ##1 brk_en && in_low_power ##1
            brk_en && in_low_power |=> break_event)
        else $error("FPU error did not break low-power.");

    copr_off_a: assert property (
        !copr_en |=> !fpu_error_interrupt && ignore_numeric_error_n)
        else $error("Coprocessor error output while disabled.");

    copr_irq_hold_a: assert property (
        fpu_error_interrupt && copr_en && !io_wr_f0 |=> fpu_error_interrupt)
        else $error("Coprocessor interrupt dropped before F0h write.");

    ignore_drive_a: assert property (
        copr_en && !fpu_error_n ##1 copr_en ##1 copr_en |=> !ignore_numeric_error_n)
        else $error("Ignore-numeric not driven.");

    kbd_pass_a: assert property (
        !kbd_en |-> kbd_irq_out == kbd_s)
        else $error("Keyboard line not passed through.");

    kbd_hold_a: assert property (
        kbd_en && kbd_irq_out && !io_rd_60 ##1 kbd_en |-> kbd_irq_out)
        else $error("Keyboard latch lost before 60h read.");

    mouse_hold_a: assert property (
        mouse_en && $rose(mouse_s) ##1 mouse_en |-> mouse_irq_out)
        else $error("Mouse edge not latched.");

    reserved_a: assert property (
        (general_control_reg & ~GENERAL_CONTROL_WMASK) == 32'h0000_0000)
        else $error("Reserved bit set.");

    side_mode_c: cover property (sel_side && !gpio_use_sel_req5 && !sideband_gnt_b_n);
    copr_irq_clear_c: cover property (fpu_error_interrupt ##1 !fpu_error_interrupt);
    kbd_latch_c: cover property (kbd_en && kbd_irq_out ##1 io_rd_60 ##1 !kbd_irq_out);
endmodule

// [test/far_side_model.sv]
// Far-side model: PCI arbiter, sideband DMA channel and legacy bridge select.
`timescale 1ns/1ps
module far_side_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Requests and address line
    input wire logic arb_req5_n,
    input wire logic sideband_req_b_n,
    input wire logic ad22_pin_out,
    // Grants and bridge select
    output logic arb_gnt5_n,
    output logic sideband_gnt_b_n,
    output logic bridge_idsel
);
    // Grants lag requests by a cycle, so the grant mux is seen with a slow master.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            arb_gnt5_n <= 1'b1;
            sideband_gnt_b_n <= 1'b1;
        end else begin
            arb_gnt5_n <= arb_req5_n;
            sideband_gnt_b_n <= sideband_req_b_n;
        end
    end
    assign bridge_idsel = ad22_pin_out;
endmodule

// [test/lpc_general_control_bench.sv]
// Directed bench for the general control register block.
`timescale 1ns/1ps
module lpc_general_control_bench;
    import gen_ctrl_pkg::*;
    logic clk, rst_b, cfg_wr, cfg_rd, io_wr_f0, io_rd_60, req5_n_pin, gnt5_n_pin;
    logic gpio_use_sel_req5, arb_req5_n, arb_gnt5_n, sideband_req_b_n, sideband_gnt_b_n;
    logic gpi_req5, gpo_gnt5, ad22_core, cfg_to_legacy_bridge, ad22_pin_out, fpu_error_n;
    logic in_low_power, break_event, fpu_error_interrupt, ignore_numeric_error_n;
    logic keyboard_interrupt, mouse_interrupt, kbd_irq_out, mouse_irq_out, bridge_idsel;
    logic [7:0] cfg_addr;
    logic [3:0] cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata;
    int n_fail = 0;
    int checks_done = 0;

    lpc_general_control dut_u (.clk(clk), .rst_b(rst_b), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .io_wr_f0(io_wr_f0), .io_rd_60(io_rd_60), .req5_n_pin(req5_n_pin),
        .gnt5_n_pin(gnt5_n_pin), .gpio_use_sel_req5(gpio_use_sel_req5),
        .arb_req5_n(arb_req5_n), .arb_gnt5_n(arb_gnt5_n), .sideband_req_b_n(sideband_req_b_n),
        .sideband_gnt_b_n(sideband_gnt_b_n), .gpi_req5(gpi_req5), .gpo_gnt5(gpo_gnt5),
        .ad22_core(ad22_core), .cfg_to_legacy_bridge(cfg_to_legacy_bridge),
        .ad22_pin_out(ad22_pin_out), .fpu_error_n(fpu_error_n), .in_low_power(in_low_power),
        .break_event(break_event), .fpu_error_interrupt(fpu_error_interrupt),
        .ignore_numeric_error_n(ignore_numeric_error_n),
        .keyboard_interrupt(keyboard_interrupt), .mouse_interrupt(mouse_interrupt),
        .kbd_irq_out(kbd_irq_out), .mouse_irq_out(mouse_irq_out));

    far_side_model far_u (.clk(clk), .rst_b(rst_b), .arb_req5_n(arb_req5_n),
        .sideband_req_b_n(sideband_req_b_n), .ad22_pin_out(ad22_pin_out),
        .arb_gnt5_n(arb_gnt5_n), .sideband_gnt_b_n(sideband_gnt_b_n),
        .bridge_idsel(bridge_idsel));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude;
        if (n_fail == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // The wr and rd tasks start and end just after a rising edge, so stimulus is sampled on the next edge.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        cfg_wr <= 1'b1;
        cfg_addr <= a;
        cfg_wdata <= d;
        @(posedge clk);
        cfg_wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        cfg_rd <= 1'b1;
        cfg_addr <= a;
        @(posedge clk);
        cfg_rd <= 1'b0;
        @(negedge clk);
        check("cfg_rdata", cfg_rdata, exp);
        @(posedge clk);
    endtask

    // Waits n edges and then samples at the falling edge, clear of updates.
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        conclude;
    end

    initial begin
        {rst_b, cfg_wr, cfg_rd, io_wr_f0, io_rd_60, gpio_use_sel_req5, ad22_core} = '0;
        {cfg_to_legacy_bridge, in_low_power, keyboard_interrupt, mouse_interrupt} = '0;
        {req5_n_pin, fpu_error_n, gpo_gnt5} = 3'b111;
        cfg_addr = 8'h00;
        cfg_be = 4'hf;
        cfg_wdata = 32'h0000_0000;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(8'hd0, 32'h0000_0000);
        wr(8'hd0, 32'hffff_ffff);
        rd(8'hd0, 32'h0320_3800);
        wr(8'hd4, 32'h0000_0000);
        rd(8'hd4, 32'h0000_0000);
        rd(8'hd0, 32'h0320_3800);
        wr(8'hd0, 32'h0000_0000);
        cfg_be <= 4'h2;
        wr(8'hd0, 32'hffff_ffff);
        cfg_be <= 4'hf;
        rd(8'hd0, 32'h0000_3800);
        wr(8'hd0, 32'h0000_0000);
        req5_n_pin <= 1'b0;
        tick(4);
        check("arb_req5_n", arb_req5_n, 1'b0);
        check("gnt5_n_pin", gnt5_n_pin, 1'b0);
        check("sideband_req_b_n", sideband_req_b_n, 1'b1);
        @(posedge clk);
        wr(8'hd0, 32'h0200_0000);
        tick(2);
        check("arb_req5_n", arb_req5_n, 1'b1);
        check("sideband_req_b_n", sideband_req_b_n, 1'b0);
        check("gnt5_n_pin", gnt5_n_pin, 1'b0);
        @(posedge clk);
        gpio_use_sel_req5 <= 1'b1;
        gpo_gnt5 <= 1'b0;
        tick(2);
        check("sideband_req_b_n", sideband_req_b_n, 1'b1);
        check("arb_req5_n", arb_req5_n, 1'b1);
        check("gnt5_n_pin", gnt5_n_pin, 1'b0);
        check("gpi_req5", gpi_req5, 1'b0);
        @(posedge clk);
        ad22_core <= 1'b1;
        cfg_to_legacy_bridge <= 1'b1;
        for (int h = 0; h < 2; h++) begin
            wr(8'hd0, 32'(h) << 24);
            tick(1);
            check("bridge_idsel", bridge_idsel, 32'(1 - h));
            @(posedge clk);
        end
        cfg_to_legacy_bridge <= 1'b0;
        tick(1);
        check("bridge_idsel", bridge_idsel, 1'b1);
        @(posedge clk);
        wr(8'hd0, 32'h0000_0000);
        in_low_power <= 1'b1;
        fpu_error_n <= 1'b0;
        tick(4);
        check("break_event", break_event, 1'b0);
        check("fpu_error_interrupt", fpu_error_interrupt, 1'b0);
        check("ignore_numeric_error_n", ignore_numeric_error_n, 1'b1);
        @(posedge clk);
        wr(8'hd0, 32'h0020_2000);
        tick(2);
        check("break_event", break_event, 1'b1);
        check("ignore_numeric_error_n", ignore_numeric_error_n, 1'b0);
        @(posedge clk);
        in_low_power <= 1'b0;
        tick(1);
        check("break_event", break_event, 1'b0);
        @(posedge clk);
        io_wr_f0 <= 1'b1;
        @(posedge clk);
        io_wr_f0 <= 1'b0;
        fpu_error_n <= 1'b1;
        tick(4);
        check("fpu_error_interrupt", fpu_error_interrupt, 1'b1);
        check("ignore_numeric_error_n", ignore_numeric_error_n, 1'b1);
        @(posedge clk);
        io_wr_f0 <= 1'b1;
        @(posedge clk);
        io_wr_f0 <= 1'b0;
        tick(2);
        check("fpu_error_interrupt", fpu_error_interrupt, 1'b0);
        @(posedge clk);
        for (int m = 0; m < 2; m++) begin
            wr(8'hd0, (m == 1) ? 32'h0000_1800 : 32'h0000_0000);
            {keyboard_interrupt, mouse_interrupt} <= 2'b11;
            tick(3);
            check("kbd_irq_out", kbd_irq_out, 1'b1);
            check("mouse_irq_out", mouse_irq_out, 1'b1);
            @(posedge clk);
            {keyboard_interrupt, mouse_interrupt} <= 2'b00;
            tick(3);
            check("kbd_irq_out", kbd_irq_out, 32'(m));
            check("mouse_irq_out", mouse_irq_out, 32'(m));
            @(posedge clk);
            io_rd_60 <= 1'b1;
            @(posedge clk);
            io_rd_60 <= 1'b0;
            tick(3);
            check("kbd_irq_out", kbd_irq_out, 1'b0);
            check("mouse_irq_out", mouse_irq_out, 1'b0);
            @(posedge clk);
        end
        conclude;
    end
endmodule
